// ===== bench/ifcd_checker_assertions.sv
// concurrent checks on the ports of the instruction format and cycle decoder
`timescale 1ns/1ps
`default_nettype none
`include "ifcd_defs.vh"
module ifcd_checker (
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic        icyc_en,
    input wire logic        instr_valid,
    input wire logic        instr_ready,
    input wire logic [23:0] instr_word,
    input wire logic        debug_en_pin,
    input wire logic        dec_valid,
    input wire logic        dec_fill,
    input wire logic        dec_nop,
    input wire logic        dec_two_word,
    input wire logic [3:0]  dec_class,
    input wire logic [1:0]  dec_cycles,
    input wire logic [9:0]  ten_bit_unsigned_literal,
    input wire logic [15:0] ten_bit_signed_literal,
    input wire logic        byte_mode,
    input wire logic [22:0] program_addr_literal,
    input wire logic [4:0]  flag_mask,
    input wire logic        err_lit_range,
    input wire logic        err_addr_align,
    input wire logic        err_mul_pair,
    input wire logic [1:0]  debug_pins_reserved
);
    logic [23:0] taken_word;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // last accepted word; a one-word issue reports it one cycle later
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) taken_word <= 24'h000000;
        else if (instr_valid && instr_ready) taken_word <= instr_word;
    end

    ready_gate_a: assert property (!icyc_en |-> !instr_ready)
        else $error("word accepted without instruction cycle enable");
    fill_two_a: assert property ((dec_valid && dec_cycles == 2'h2
        && dec_class != `IFCD_CL_SKIP && icyc_en) |=> dec_fill)
        else $error("two-cycle issue not followed by a fill cycle");
    fill_three_a: assert property ((dec_valid && dec_cycles == 2'h3 && icyc_en)
        ##1 icyc_en |-> dec_fill && !instr_ready)
        else $error("three-cycle issue released fetch too early");
    pair_shape_a: assert property (dec_valid && dec_two_word |-> dec_cycles == 2'h2
        && err_addr_align == program_addr_literal[0])
        else $error("two-word issue has wrong cycle count or alignment flag");
    nop_word_a: assert property (dec_valid && dec_nop |-> dec_cycles == 2'h1
        && !dec_two_word && flag_mask == `IFCD_FL_NONE)
        else $error("lone second word not issued as a no-operation");
    alu_flags_a: assert property (dec_valid && (dec_class == `IFCD_CL_ALUF
        || dec_class == `IFCD_CL_ALUW) |-> flag_mask == `IFCD_FL_ALL)
        else $error("arithmetic class flag mask wrong");
    lit_limit_a: assert property (dec_valid && dec_class == `IFCD_CL_LIT
        |-> err_lit_range == (byte_mode && ten_bit_unsigned_literal > `IFCD_BYTE_LIT_MAX))
        else $error("byte literal range flag wrong");
    sign_ext_a: assert property (dec_valid |-> ten_bit_signed_literal
        == {{6{ten_bit_unsigned_literal[9]}}, ten_bit_unsigned_literal})
        else $error("signed literal not sign extended");
    square_pair_a: assert property (dec_valid && dec_class == `IFCD_CL_MULSQ
        |-> err_mul_pair == !(taken_word[3:0] == taken_word[7:4] && taken_word[3:2] == 2'h1))
        else $error("square register pair check wrong");
    dsp_pair_a: assert property (dec_valid && dec_class == `IFCD_CL_MULDSP
        |-> err_mul_pair == !(taken_word[3:2] == 2'h1 && taken_word[7:6] == 2'h1
        && taken_word[3:0] < taken_word[7:4]))
        else $error("signal multiply register pair check wrong");
    debug_pins_a: assert property (debug_en_pin [*3] |-> debug_pins_reserved == 2'h3)
        else $error("debug pins not reserved after enable");
endmodule // ifcd_checker

bind ifcd_decoder ifcd_checker u_ifcd_checker (.*);
`default_nettype wire

// ===== bench/ifcd_fetch_model.sv
// fetch-side model that offers queued instruction words to the decoder
`timescale 1ns/1ps
`default_nettype none
module ifcd_fetch_model (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        instr_ready,
    output var  logic        instr_valid,
    output var  logic [23:0] instr_word,
    output var  logic        cond_true
);
    logic [24:0] pend_q[$];

    // queues one word with the condition outcome that goes with it
    task automatic push(input logic [23:0] w, input logic c);
        pend_q.push_back({c, w});
    endtask

    // an offered word holds until taken; an idle bus shows the inverse so stale data never matches
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            instr_valid <= 1'b0;
            instr_word  <= 24'h000000;
            cond_true   <= 1'b0;
        end else if (!instr_valid || instr_ready) begin
            if (instr_valid) void'(pend_q.pop_front());
            if (pend_q.size() > 0) begin
                {cond_true, instr_word} <= pend_q[0];
                instr_valid <= 1'b1;
            end else begin
                instr_valid <= 1'b0;
                instr_word  <= ~instr_word;
                cond_true   <= ~cond_true;
            end
        end
    end
endmodule // ifcd_fetch_model
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench for the instruction format and cycle decoder
`timescale 1ns/1ps
`default_nettype none
`include "ifcd_defs.vh"
module testbench;
    logic             clk_sys = 1'b0;
    logic             nrst = 1'b0;
    logic             icyc_en = 1'b0;
    logic             debug_en_pin = 1'b0;
    wire logic        instr_valid, instr_ready, cond_true, dec_valid, dec_fill, dec_nop;
    wire logic        dec_two_word, dest_is_default_working_reg, byte_mode, err_lit_range;
    wire logic        err_addr_align, err_second_word, err_mul_pair, err_debug_ram;
    wire logic [23:0] instr_word;
    wire logic [7:0]  dec_opcode;
    wire logic [3:0]  dec_class, base_operand_reg, source_operand_reg, dest_operand_reg;
    wire logic [3:0]  bit_select_field;
    wire logic [1:0]  dec_cycles, source_mode, dest_mode, debug_pins_reserved;
    wire logic [12:0] file_addr;
    wire logic [9:0]  ten_bit_unsigned_literal;
    wire logic [15:0] ten_bit_signed_literal;
    wire logic [22:0] program_addr_literal;
    wire logic [4:0]  flag_mask;
    int               err_total = 0;
    int               samples_checked = 0;
    bit               seen_valid = 1'b0;

    ifcd_decoder u_ifcd_decoder (.*);
    ifcd_fetch_model u_ifcd_fetch_model (.*);

    always #2 clk_sys = ~clk_sys; // 250 MHz

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // waits for the next issue unless a fill count already ran into it
    task automatic wait_issue;
        int i;
        i = 0;
        if (seen_valid) seen_valid = 1'b0;
        else do begin
            @(posedge clk_sys);
            #1;
            i++;
        end while (dec_valid !== 1'b1 && i < 20);
        check(dec_valid, 1'b1);
    endtask

    task automatic issue(input logic [23:0] w, input logic c);
        u_ifcd_fetch_model.push(w, c);
        wait_issue;
    endtask

    // counts fill pulses until the next issue shows up, four cycles at most
    task automatic tail(output int n);
        n = 0;
        for (int i = 0; i < 4 && !seen_valid; i++) begin
            @(posedge clk_sys);
            #1;
            if (dec_valid === 1'b1) seen_valid = 1'b1;
            else if (dec_fill === 1'b1) n++;
        end
    endtask

    task automatic t_fields;
        issue(24'h403fff, 1'b0);
        check(file_addr, 13'h1fff);
        check(dest_is_default_working_reg, 1'b0);
        check(dec_cycles, 2'h1);
        issue(24'h404000, 1'b0);
        check(file_addr, 13'h0000);
        check(dest_is_default_working_reg, 1'b1);
        issue(24'h60a57f, 1'b0);
        check(dec_opcode, 8'h60);
        check(base_operand_reg, 4'ha);
        check({dest_mode, dest_operand_reg}, 6'h15);
        check({source_mode, source_operand_reg}, 6'h3f);
        issue(24'ha0f000, 1'b0);
        check(bit_select_field, 4'hf);
    endtask

    task automatic t_lit;
        logic [23:0] w [4] = '{24'h804ff0, 24'h805000, 24'h803ff0, 24'h802000};
        logic        e [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
        logic [15:0] s [4] = '{16'h00ff, 16'h0100, 16'hffff, 16'hfe00};
        for (int i = 0; i < 4; i++) begin
            issue(w[i], 1'b0);
            check(err_lit_range, e[i]);
            check(ten_bit_signed_literal, s[i]);
            check(flag_mask, `IFCD_FL_NZ);
        end
    endtask

    // unconditional, indirect, table, returns, then a conditional branch taken and not
    task automatic t_control;
        logic [7:0] op [8] = '{8'h37, 8'h01, 8'hba, 8'hbb, 8'h06, 8'h07, 8'h30, 8'h30};
        logic       c [8]  = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
        int         cy [8] = '{2, 2, 2, 2, 3, 3, 2, 1};
        int         n;
        for (int i = 0; i < 8; i++) begin
            issue({op[i], 16'h0000}, c[i]);
            check(dec_cycles, cy[i]);
            tail(n);
            check(n, cy[i] - 1);
        end
    endtask

    task automatic t_pairs;
        logic [7:0] op [3] = '{8'h02, 8'h04, 8'h0c};
        int         n;
        for (int i = 0; i < 3; i++) begin
            u_ifcd_fetch_model.push({op[i], 16'h1234}, 1'b0);
            issue(24'h00007f, 1'b0);
            check({dec_two_word, dec_opcode}, {1'b1, op[i]});
            check(dec_cycles, 2'h2);
            check(program_addr_literal, 23'h7f1234);
            check({err_addr_align, err_second_word}, 2'h0);
            tail(n);
            check(n, 1);
        end
        u_ifcd_fetch_model.push(24'h041235, 1'b0);
        issue(24'h01007f, 1'b0);
        check(err_addr_align, 1'b1);
        check(err_second_word, 1'b1);
        tail(n);
        issue(24'h00abcd, 1'b0);
        check({dec_nop, dec_two_word, dec_cycles}, 4'h9);
        tail(n);
        check(n, 0);
    endtask

    // taken skip over a pair, untaken skip, taken skip over one word
    task automatic t_skip;
        int n;
        u_ifcd_fetch_model.push(24'hb00000, 1'b1);
        u_ifcd_fetch_model.push(24'h041000, 1'b0);
        u_ifcd_fetch_model.push(24'h000001, 1'b0);
        issue(24'h400010, 1'b0);
        check(dec_opcode, 8'hb0);
        tail(n);
        check(n, 2);
        wait_issue;
        check(file_addr, 13'h0010);
        u_ifcd_fetch_model.push(24'hb00000, 1'b0);
        issue(24'h400020, 1'b0);
        check(dec_cycles, 2'h1);
        wait_issue;
        check(file_addr, 13'h0020);
        u_ifcd_fetch_model.push(24'hb00000, 1'b1);
        u_ifcd_fetch_model.push(24'h400030, 1'b0);
        issue(24'h400040, 1'b0);
        tail(n);
        check(n, 1);
        wait_issue;
        check(file_addr, 13'h0040);
    endtask

    task automatic t_mul;
        logic [23:0] w [9] = '{24'hf00044, 24'hf00077, 24'hf00033, 24'hf00054, 24'hf10054,
                               24'hf10076, 24'hf10045, 24'hf10077, 24'hf10084};
        logic        e [9] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
        for (int i = 0; i < 9; i++) begin
            issue(w[i], 1'b0);
            check(err_mul_pair, e[i]);
        end
    endtask

    task automatic t_debug;
        @(posedge clk_sys);
        debug_en_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        check(debug_pins_reserved, 2'h3);
        issue(24'h40004f, 1'b0);
        check(err_debug_ram, 1'b1);
        issue(24'h400050, 1'b0);
        check(err_debug_ram, 1'b0);
        @(posedge clk_sys);
        debug_en_pin <= 1'b0;
    endtask

    // fetch must wait while instruction cycles are withheld; nothing may be lost
    task automatic t_stall;
        @(posedge clk_sys);
        icyc_en <= 1'b0;
        u_ifcd_fetch_model.push(24'h400001, 1'b0);
        repeat (3) begin
            @(posedge clk_sys);
            #1;
            check({instr_ready, dec_valid}, 2'h0);
        end
        @(posedge clk_sys);
        icyc_en <= 1'b1;
        wait_issue;
        check(file_addr, 13'h0001);
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        icyc_en <= 1'b1;
        t_fields;
        t_lit;
        t_control;
        t_pairs;
        t_skip;
        t_mul;
        t_debug;
        t_stall;
        results;
    end

    // the whole sequence needs well under a thousand cycles
    initial begin
        #20000;
        err_total++;
        results;
    end
endmodule // testbench
`default_nettype wire

// ===== design/ifcd_decoder.v
// instruction format and instruction cycle decoder
`timescale 1ns/1ps
`default_nettype none
`include "ifcd_defs.vh"

// What this block does
// - a one-word instruction is 24 bits with an 8-bit opcode plus operand fields
// - exactly three opcodes take two words; both are fetched before issue
// - the second word of a pair must carry an all-zero top byte
// - a second word executed alone issues as a no-operation
// - one cycle normally; two or three when a test is true or the pc changes
// - taken branches, indirect calls, table access and returns take two or three cycles; an untaken branch takes one
// - a taken skip costs two cycles, three when it skips a two-word instruction
// - every two-word instruction takes two cycles
// - the file register address spans zero to 0x1fff
// - the bit select field is 4 bits, positions 0 to 15
// - the unsigned 10-bit literal stays at or below 255 in byte mode
// - the 23-bit program address literal must have its lsb at zero
// - the signed 10-bit literal is two's complement, -512 to 511
// - squaring multiplies accept only equal pairs of w4 to w7
// - signal multiplies accept only the six distinct ascending pairs of w4 to w7
// - file register forms give an address and a select of file or w0
// - three-operand forms give base, moded source and moded destination registers
// - updatable flags are carry, digit carry, negative, overflow and sticky zero
// - with debug enabled the first 80 ram bytes and two pins are reserved
module ifcd_decoder (
    input  wire        clk_sys,
    input  wire        nrst,
    input  wire        icyc_en,
    input  wire        instr_valid,
    output wire        instr_ready,
    input  wire [23:0] instr_word,
    input  wire        cond_true,
    input  wire        debug_en_pin,
    output reg         dec_valid,
    output reg         dec_fill,
    output reg         dec_nop,
    output reg         dec_two_word,
    output reg  [7:0]  dec_opcode,
    output reg  [3:0]  dec_class,
    output reg  [1:0]  dec_cycles,
    output reg  [3:0]  base_operand_reg,
    output reg  [3:0]  source_operand_reg,
    output reg  [1:0]  source_mode,
    output reg  [3:0]  dest_operand_reg,
    output reg  [1:0]  dest_mode,
    output reg  [12:0] file_addr,
    output reg         dest_is_default_working_reg,
    output reg         byte_mode,
    output reg  [3:0]  bit_select_field,
    output reg  [9:0]  ten_bit_unsigned_literal,
    output reg  [15:0] ten_bit_signed_literal,
    output reg  [22:0] program_addr_literal,
    output reg  [4:0]  flag_mask,
    output reg         err_lit_range,
    output reg         err_addr_align,
    output reg         err_second_word,
    output reg         err_mul_pair,
    output reg         err_debug_ram,
    output wire [1:0]  debug_pins_reserved
);

    // one-hot sequencer states
    localparam [3:0] S_FETCH = 4'h1;
    localparam [3:0] S_WORD2 = 4'h2;
    localparam [3:0] S_FILL  = 4'h4;
    localparam [3:0] S_SKIP  = 4'h8;

    reg [3:0]  state;
    reg [23:0] first_word;
    reg [1:0]  fill_cnt;
    reg        skip_pair;
    reg        dbg_meta;
    reg        dbg_en;

    // class of an opcode; ranges are checked most specific first
    function [3:0] ifcd_class;
        input [7:0] op;
        begin
            if (op == `IFCD_OP_ZERO)
                ifcd_class = `IFCD_CL_WORD2;
            else if (op == `IFCD_OP_CALL2 || op == `IFCD_OP_JUMP2 || op == `IFCD_OP_MOVD2)
                ifcd_class = `IFCD_CL_TWO;
            else if (op == `IFCD_OP_BRA_UNC || op == `IFCD_OP_CALL_IND)
                ifcd_class = `IFCD_CL_LONG2;
            else if (op == `IFCD_OP_RET || op == `IFCD_OP_RETI)
                ifcd_class = `IFCD_CL_LONG3;
            else if (op >= `IFCD_OP_BRA_LO && op <= `IFCD_OP_BRA_HI)
                ifcd_class = `IFCD_CL_BRA_C;
            else if (op >= `IFCD_OP_ALUF_LO && op <= `IFCD_OP_ALUF_HI)
                ifcd_class = `IFCD_CL_ALUF;
            else if (op >= `IFCD_OP_ALUW_LO && op <= `IFCD_OP_ALUW_HI)
                ifcd_class = `IFCD_CL_ALUW;
            else if (op >= `IFCD_OP_LIT_LO && op <= `IFCD_OP_LIT_HI)
                ifcd_class = `IFCD_CL_LIT;
            else if (op >= `IFCD_OP_BIT_LO && op <= `IFCD_OP_BIT_HI)
                ifcd_class = `IFCD_CL_BIT;
            else if (op >= `IFCD_OP_SKIP_LO && op <= `IFCD_OP_SKIP_HI)
                ifcd_class = `IFCD_CL_SKIP;
            else if (op >= `IFCD_OP_TBL_LO && op <= `IFCD_OP_TBL_HI)
                ifcd_class = `IFCD_CL_LONG2;
            else if (op == `IFCD_OP_MULSQ)
                ifcd_class = `IFCD_CL_MULSQ;
            else if (op == `IFCD_OP_MULDSP)
                ifcd_class = `IFCD_CL_MULDSP;
            else
                ifcd_class = `IFCD_CL_OTHER;
        end
    endfunction

    // instruction cycles charged at issue; a taken skip adds its fill later
    function [1:0] ifcd_cycles;
        input [3:0] cl;
        input       taken;
        begin
            case (cl)
                `IFCD_CL_TWO:   ifcd_cycles = 2'h2;
                `IFCD_CL_LONG2: ifcd_cycles = 2'h2;
                `IFCD_CL_LONG3: ifcd_cycles = 2'h3;
                `IFCD_CL_BRA_C: ifcd_cycles = taken ? 2'h2 : 2'h1;
                `IFCD_CL_SKIP:  ifcd_cycles = taken ? 2'h2 : 2'h1;
                default:        ifcd_cycles = 2'h1;
            endcase
        end
    endfunction

    // flags an instruction class may update
    function [4:0] ifcd_flags;
        input [3:0] cl;
        begin
            case (cl)
                `IFCD_CL_ALUF:  ifcd_flags = `IFCD_FL_ALL;
                `IFCD_CL_ALUW:  ifcd_flags = `IFCD_FL_ALL;
                `IFCD_CL_LIT:   ifcd_flags = `IFCD_FL_NZ;
                default:        ifcd_flags = `IFCD_FL_NONE;
            endcase
        end
    endfunction

    // the word presented now and its class
    wire [7:0] in_op    = instr_word[`IFCD_OP_HI:`IFCD_OP_LO];
    wire [3:0] in_class = ifcd_class(in_op);
    wire       in_two   = (in_class == `IFCD_CL_TWO);
    wire       taken    = cond_true;
    wire       accept   = instr_valid && instr_ready;

    // fields come from the first word of the instruction; the address top bits and the second-word check read word two
    wire [23:0] fw = (state == S_WORD2) ? first_word : instr_word;
    wire [3:0]  fw_class = ifcd_class(fw[`IFCD_OP_HI:`IFCD_OP_LO]);
    wire [3:0]  m_wm = fw[`IFCD_SRC_HI:`IFCD_SRC_LO];
    wire [3:0]  m_wn = fw[`IFCD_MWN_HI:`IFCD_MWN_LO];
    wire        m_lo = (m_wm >= `IFCD_MUL_REG_MIN) && (m_wm <= `IFCD_MUL_REG_MAX);
    wire        m_hi = (m_wn >= `IFCD_MUL_REG_MIN) && (m_wn <= `IFCD_MUL_REG_MAX);
    wire        sq_ok  = m_lo && (m_wm == m_wn);
    wire        dsp_ok = m_lo && m_hi && (m_wm < m_wn);
    wire [9:0]  lit = fw[`IFCD_LIT_HI:`IFCD_LIT_LO];
    wire [12:0] fad = fw[`IFCD_F_HI:`IFCD_F_LO];
    wire        issue_one = accept && (state == S_FETCH) && !in_two;
    wire        issue_two = accept && (state == S_WORD2);
    wire        issue = issue_one || issue_two;
    wire [1:0]  cyc_now = issue_two ? 2'h2 : ifcd_cycles(in_class, taken);

    // fetch is taken only in an instruction cycle and not while filling
    assign instr_ready = icyc_en && (state != S_FILL);

    // debug enable is a pin level, so two flops before use
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dbg_meta <= 1'b0;
            dbg_en   <= 1'b0;
        end else begin
            dbg_meta <= debug_en_pin;
            dbg_en   <= dbg_meta;
        end
    end

    // two pins are lost to the debugger while it is enabled
    assign debug_pins_reserved = {dbg_en, dbg_en};

    // sequencer: gathers pairs, then holds fetch off for extra cycles
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state      <= S_FETCH;
            first_word <= 24'h000000;
            fill_cnt   <= 2'h0;
            skip_pair  <= 1'b0;
            dec_fill   <= 1'b0;
        end else begin
            dec_fill <= 1'b0;
            case (state)
                S_FETCH: begin
                    if (accept) begin
                        if (in_two) begin
                            first_word <= instr_word;
                            state      <= S_WORD2;
                        end else if (in_class == `IFCD_CL_SKIP && taken) begin
                            skip_pair <= 1'b0;
                            state     <= S_SKIP;
                        end else if (cyc_now != 2'h1) begin
                            fill_cnt <= cyc_now - 2'h1;
                            state    <= S_FILL;
                        end
                    end
                end
                S_WORD2: begin
                    if (accept) begin
                        fill_cnt <= 2'h1;
                        state    <= S_FILL;
                    end
                end
                S_FILL: begin
                    if (icyc_en) begin
                        dec_fill <= 1'b1;
                        fill_cnt <= fill_cnt - 2'h1;
                        if (fill_cnt == 2'h1)
                            state <= S_FETCH;
                    end
                end
                S_SKIP: begin
                    // the skipped word is swallowed as a nop cycle
                    if (accept) begin
                        dec_fill <= 1'b1;
                        if (!skip_pair && in_two)
                            skip_pair <= 1'b1;
                        else
                            state <= S_FETCH;
                    end
                end
                default: state <= S_FETCH;
            endcase
        end
    end

    // decoded fields, captured once per issued instruction
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dec_valid                   <= 1'b0;
            dec_nop                     <= 1'b0;
            dec_two_word                <= 1'b0;
            dec_opcode                  <= 8'h00;
            dec_class                   <= `IFCD_CL_OTHER;
            dec_cycles                  <= 2'h0;
            base_operand_reg            <= 4'h0;
            source_operand_reg          <= 4'h0;
            source_mode                 <= 2'h0;
            dest_operand_reg            <= 4'h0;
            dest_mode                   <= 2'h0;
            file_addr                   <= 13'h0000;
            dest_is_default_working_reg <= 1'b0;
            byte_mode                   <= 1'b0;
            bit_select_field            <= 4'h0;
            ten_bit_unsigned_literal    <= 10'h000;
            ten_bit_signed_literal      <= 16'h0000;
            program_addr_literal        <= 23'h000000;
            flag_mask                   <= `IFCD_FL_NONE;
            err_lit_range               <= 1'b0;
            err_addr_align              <= 1'b0;
            err_second_word             <= 1'b0;
            err_mul_pair                <= 1'b0;
            err_debug_ram               <= 1'b0;
        end else begin
            dec_valid <= issue;
            if (issue) begin
                dec_opcode   <= fw[`IFCD_OP_HI:`IFCD_OP_LO];
                dec_class    <= fw_class;
                dec_two_word <= issue_two;
                dec_nop      <= (fw_class == `IFCD_CL_WORD2);
                dec_cycles   <= cyc_now;
                flag_mask    <= ifcd_flags(fw_class);
                // register fields: 4 bits reach all sixteen registers
                base_operand_reg   <= fw[`IFCD_BASE_HI:`IFCD_BASE_LO];
                source_operand_reg <= fw[`IFCD_SRC_HI:`IFCD_SRC_LO];
                source_mode        <= fw[`IFCD_SMOD_HI:`IFCD_SMOD_LO];
                dest_operand_reg   <= fw[`IFCD_DST_HI:`IFCD_DST_LO];
                dest_mode          <= fw[`IFCD_DMOD_HI:`IFCD_DMOD_LO];
                // file forms: select low means the result goes to w0
                file_addr                   <= fad;
                dest_is_default_working_reg <= !fw[`IFCD_DSEL_BIT];
                byte_mode                   <= fw[`IFCD_BYTE_BIT];
                bit_select_field            <= fw[`IFCD_BASE_HI:`IFCD_BASE_LO];
                ten_bit_unsigned_literal    <= lit;
                ten_bit_signed_literal      <= {{6{lit[9]}}, lit};
                err_lit_range <= (fw_class == `IFCD_CL_LIT) && fw[`IFCD_BYTE_BIT]
                                 && (lit > `IFCD_BYTE_LIT_MAX);
                err_mul_pair  <= ((fw_class == `IFCD_CL_MULSQ) && !sq_ok)
                                 || ((fw_class == `IFCD_CL_MULDSP) && !dsp_ok);
                err_debug_ram <= dbg_en && (fw_class == `IFCD_CL_ALUF)
                                 && (fad < `IFCD_DBG_RAM_BYTES);
                if (issue_two) begin
                    // address: 16 low bits from word one, 7 high from word two
                    program_addr_literal <= {instr_word[`IFCD_PA2_HI:`IFCD_PA2_LO],
                                             first_word[15:0]};
                    err_addr_align  <= first_word[0];
                    err_second_word <= (in_op != `IFCD_OP_ZERO);
                end else begin
                    program_addr_literal <= 23'h000000;
                    err_addr_align       <= 1'b0;
                    err_second_word      <= 1'b0;
                end
            end
        end
    end

endmodule // ifcd_decoder

`default_nettype wire

// ===== design/ifcd_defs.vh
// constants for the instruction format and cycle decoder
`ifndef IFCD_DEFS_VH
`define IFCD_DEFS_VH

// word layout
`define IFCD_WORD_W        24
`define IFCD_OP_HI         23
`define IFCD_OP_LO         16
`define IFCD_OP_W          8
`define IFCD_OP_ZERO       8'h00

// opcodes of the three two-word instructions and the class boundaries
`define IFCD_OP_CALL2      8'h02
`define IFCD_OP_JUMP2      8'h04
`define IFCD_OP_MOVD2      8'h0c
`define IFCD_OP_BRA_UNC    8'h37
`define IFCD_OP_CALL_IND   8'h01
`define IFCD_OP_RET        8'h06
`define IFCD_OP_RETI       8'h07
`define IFCD_OP_BRA_LO     8'h30
`define IFCD_OP_BRA_HI     8'h3f
`define IFCD_OP_ALUF_LO    8'h40
`define IFCD_OP_ALUF_HI    8'h5f
`define IFCD_OP_ALUW_LO    8'h60
`define IFCD_OP_ALUW_HI    8'h7f
`define IFCD_OP_LIT_LO     8'h80
`define IFCD_OP_LIT_HI     8'h8f
`define IFCD_OP_BIT_LO     8'ha0
`define IFCD_OP_BIT_HI     8'haf
`define IFCD_OP_SKIP_LO    8'hb0
`define IFCD_OP_SKIP_HI    8'hb7
`define IFCD_OP_TBL_LO     8'hba
`define IFCD_OP_TBL_HI     8'hbb
`define IFCD_OP_MULSQ      8'hf0
`define IFCD_OP_MULDSP     8'hf1

// instruction classes
`define IFCD_CL_W          4
`define IFCD_CL_OTHER      4'h0
`define IFCD_CL_WORD2      4'h1
`define IFCD_CL_TWO        4'h2
`define IFCD_CL_BRA_C      4'h3
`define IFCD_CL_LONG2      4'h4
`define IFCD_CL_LONG3      4'h5
`define IFCD_CL_ALUF       4'h6
`define IFCD_CL_ALUW       4'h7
`define IFCD_CL_LIT        4'h8
`define IFCD_CL_BIT        4'h9
`define IFCD_CL_SKIP       4'ha
`define IFCD_CL_MULSQ      4'hb
`define IFCD_CL_MULDSP     4'hc

// field positions
`define IFCD_SRC_HI        3
`define IFCD_SRC_LO        0
`define IFCD_SMOD_HI       5
`define IFCD_SMOD_LO       4
`define IFCD_DST_HI        9
`define IFCD_DST_LO        6
`define IFCD_DMOD_HI       11
`define IFCD_DMOD_LO       10
`define IFCD_BASE_HI       15
`define IFCD_BASE_LO       12
`define IFCD_F_HI          12
`define IFCD_F_LO          0
`define IFCD_DSEL_BIT      13
`define IFCD_BYTE_BIT      14
`define IFCD_LIT_HI        13
`define IFCD_LIT_LO        4
`define IFCD_MWN_HI        7
`define IFCD_MWN_LO        4
`define IFCD_PA2_HI        6
`define IFCD_PA2_LO        0

// limits
`define IFCD_BYTE_LIT_MAX  10'h0ff
`define IFCD_MUL_REG_MIN   4'h4
`define IFCD_MUL_REG_MAX   4'h7
`define IFCD_DBG_RAM_BYTES 13'h0050

// status flag mask bits {c, dc, n, ov, z}
`define IFCD_FL_ALL        5'h1f
`define IFCD_FL_NZ         5'h05
`define IFCD_FL_NONE       5'h00

`endif
